// [rtl/prescaler_defines.svh]
// Offsets, field positions, reset values and tap positions of the prescaler and input port.
`ifndef PRESCALER_DEFINES_SVH
`define PRESCALER_DEFINES_SVH

// ************************************************************
// Divider chain
// ************************************************************
`define DIV_WIDTH          15
`define TAP_RESET_VALUE    15'h7FFE
`define TAP_CK14           1
`define TAP_CK11           4
`define TAP_CK8            7
`define TAP_CK6            9
`define TAP_CK4            11
`define TAP_CK2            13
`define TAP_CK1            14
`define CLEAR_TAPS         13'h0000

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_PRESC_CTRL     6'h00
`define OFS_PIN_LEVEL      6'h04
`define OFS_PIN_MASK       6'h08
`define OFS_PIN_REQUEST    6'h0C
`define OFS_PIN_EDGE       6'h10
`define OFS_PIN_BYPASS     6'h14
`define OFS_PIN_NOPULL     6'h18
`define OFS_FUNC_OPTION    6'h1C
`define OFS_RESET_SELECT   6'h20
`define OFS_DIVIDER        6'h24

// ************************************************************
// Fields and reset values
// ************************************************************
`define CTRL_PWM_BIT       3
`define CTRL_CLEAR_BIT     2
`define CTRL_IRQSEL_BIT    1
`define CTRL_DEBOUNCE_CLOCK_SELECT_BIT    0
`define OPT_SLEEP_RST_BIT  0
`define PIN_RESET_VALUE    4'h0
`define RSEL_RESET_VALUE   8'h00

`endif

// [rtl/prescaler_pkg.sv]
// Types shared by the prescaler and input port logic.
package prescaler_pkg;

    typedef struct packed {
        logic [3:0] mask;
        logic [3:0] edge_sel;
        logic [3:0] bypass;
        logic [3:0] no_pull;
    } pin_cfg_t;

    typedef struct packed {
        logic pwm_en;
        logic irq_sel;
        logic deb_sel;
        logic sleep_rst_en;
    } presc_cfg_t;

    typedef enum logic [1:0] {
        TERM_LOW,
        TERM_PIN,
        TERM_INV,
        TERM_HIGH
    } reset_term_t;

endpackage

// [rtl/prescaler_port_irq.sv]
// Prescaler divider chain with periodic strobes and the four-pin input port with interrupt requests.
`timescale 1ns/1ps
`include "prescaler_defines.svh"

// ************************************************************
// Operation
// ************************************************************
// Operation
// - Fifteen-stage divider gives taps from clock divided by 2 down to clock divided by 32768.
// - Power-on loads the divider chain with 7FFE, the inverse of one.
// - Writing one to the clear bit clears middle taps, sets 1 Hz tap; reads zero.
// - Periodic strobe on rising divide-by-4096 tap, or divide-by-1024 when selected.
// - Debounce clock is divide-by-256 tap, or divide-by-32 or divide-by-4 by build option.
// - One-second strobe on each rising edge of the 1 Hz tap.
// - Blink strobe three quarters of the way through each 1 Hz period.
// - Leaving reset raises no prescaler strobe.
// - First one-second strobe comes one second after reset at 32 kHz.
// - Sleep disables pins and pulls unless sleep reset option set; then combination resets at once.
// - Debounced pin change accepted only after stable across two debounce clock edges.
// - Each pin requests on its selected edge of debounced or direct value.
// - Each pin has its own mask bit; software reads request flags to identify sources.
// - Every reset clears all four pin mask bits.
// - Only active edges seen while unmasked are stored; masked edges are lost.
// - Changing a pin edge selection acts as a possible edge event.
// - Software can read live pin levels at any time.
// - Debounce, edge and pull options are set per pin independently.
// - Input reset is AND of four selectable terms, debounced while awake.
// - Writing one clears a request flag; writing zero leaves it; flags reset to zero.
// - Edge select defaults to zero, rising; one selects falling.
// - Debounce bypass defaults to zero, debounced; one selects direct input.

module prescaler_port_irq #(
    parameter bit FAST_DEB_CK14 = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [3:0]  input_port_pin,
    input  wire logic        sleep_mode,
    output logic [14:0]      divider_tap,
    output logic             selectable_periodic_irq,
    output logic             one_second_irq,
    output logic             blink_irq,
    output logic             pulse_width_output_enable,
    output logic [3:0]       pin_input_enable,
    output logic [3:0]       pin_pull_enable,
    output logic             input_reset_combination
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Per bit, take the new value only where two samples agree.
    function automatic logic [3:0] stable_step(input logic [3:0] smp,
                                               input logic [3:0] cur,
                                               input logic [3:0] val);
        logic [3:0] diff;
        diff = smp ^ cur;
        return (~diff & cur) | (diff & val);
    endfunction

    function automatic logic reset_term(input logic [1:0] sel, input logic pin);
        logic t;
        case (prescaler_pkg::reset_term_t'(sel))
            prescaler_pkg::TERM_LOW:  t = 1'b0;
            prescaler_pkg::TERM_PIN:  t = pin;
            prescaler_pkg::TERM_INV:  t = ~pin;
            prescaler_pkg::TERM_HIGH: t = 1'b1;
            default:                  t = 1'b0;
        endcase
        return t;
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    prescaler_pkg::presc_cfg_t cfg_q;
    prescaler_pkg::pin_cfg_t   pin_cfg_q;
    logic [3:0]  req_q;
    logic [7:0]  rsel_q;
    logic        ack_q;
    logic        wr_hit;
    logic        clear_wr;
    logic [3:0]  req_clr;

    // A request is answered one edge after it is seen and committed on the next.
    assign wr_hit   = write & ack_q;
    assign clear_wr = wr_hit & (address == `OFS_PRESC_CTRL) & writedata[`CTRL_CLEAR_BIT];
    assign req_clr  = (wr_hit && address == `OFS_PIN_REQUEST) ? writedata[3:0] : 4'h0;

    // The wait flag is a flop of its own so that the bus pin leaves a register, not an inverter.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q       <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            ack_q       <= (read | write) & ~ack_q;
            waitrequest <= ~((read | write) & ~ack_q);
        end
    end

    // ************************************************************
    // Divider chain
    // ************************************************************
    // The tap vector counts down, so each tap is the inverse of an up-counter bit.
    // That places the first 1 Hz rising edge a full period after reset.
    logic [14:0] tap_q;
    logic [14:0] tap_prev_q;
    logic        per_prev_q;
    logic        deb_prev_q;
    logic        per_lvl;
    logic        deb_lvl;
    logic        blink_lvl;
    logic        blink_prev_q;
    logic        deb_tick;
    logic        ck8_tick;

    always_ff @(posedge clk) begin
        if (reset) begin
            tap_q <= `TAP_RESET_VALUE;
        end else if (clear_wr) begin
            tap_q <= {1'b1, `CLEAR_TAPS, tap_q[0]};
        end else begin
            tap_q <= tap_q - 15'h0001;
        end
    end

    assign divider_tap = tap_q;
    assign per_lvl     = cfg_q.irq_sel ? tap_q[`TAP_CK6] : tap_q[`TAP_CK4];
    assign deb_lvl     = cfg_q.deb_sel ? (FAST_DEB_CK14 ? tap_q[`TAP_CK14] : tap_q[`TAP_CK11])
                                       : tap_q[`TAP_CK8];
    assign blink_lvl   = ~tap_q[`TAP_CK1] & ~tap_q[`TAP_CK2];
    assign deb_tick    = deb_lvl & ~deb_prev_q;
    assign ck8_tick    = tap_q[`TAP_CK8] & ~tap_prev_q[`TAP_CK8];

    // Edge history starts at the reset tap levels so that reset itself is no edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            tap_prev_q   <= `TAP_RESET_VALUE;
            per_prev_q   <= 1'b1;
            deb_prev_q   <= 1'b1;
            blink_prev_q <= 1'b0;
        end else begin
            tap_prev_q   <= tap_q;
            per_prev_q   <= per_lvl;
            deb_prev_q   <= deb_lvl;
            blink_prev_q <= blink_lvl;
        end
    end

    // A change of the periodic selection can itself look like an edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            selectable_periodic_irq <= 1'b0;
            one_second_irq          <= 1'b0;
            blink_irq               <= 1'b0;
        end else begin
            selectable_periodic_irq <= per_lvl & ~per_prev_q;
            one_second_irq          <= tap_q[`TAP_CK1] & ~tap_prev_q[`TAP_CK1];
            blink_irq               <= blink_lvl & ~blink_prev_q;
        end
    end

    // ************************************************************
    // Input port
    // ************************************************************
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_s3_q;
    logic [3:0] pin_q;
    logic [3:0] deb_smp_q;
    logic [3:0] deb_q;
    logic [3:0] lvl_prev_q;
    logic [3:0] src;
    logic [3:0] lvl;
    logic [3:0] edge_ev;
    logic       awake_pins;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
            pin_q    <= 4'h0;
        end else begin
            pin_s1_q <= input_port_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= stable_step(pin_s2_q, pin_s3_q, pin_q);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            deb_smp_q <= 4'h0;
            deb_q     <= 4'h0;
        end else if (deb_tick) begin
            deb_smp_q <= pin_q;
            deb_q     <= stable_step(deb_smp_q, pin_q, deb_q);
        end
    end

    assign src     = (pin_cfg_q.bypass & pin_q) | (~pin_cfg_q.bypass & deb_q);
    assign lvl     = src ^ pin_cfg_q.edge_sel;
    assign edge_ev = lvl & ~lvl_prev_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            lvl_prev_q <= 4'h0;
        end else begin
            lvl_prev_q <= lvl;
        end
    end

    // A new edge wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            req_q <= 4'h0;
        end else begin
            req_q <= (req_q & ~req_clr) | (edge_ev & pin_cfg_q.mask);
        end
    end

    // ************************************************************
    // Sleep and input reset
    // ************************************************************
    logic combo_now;
    logic combo_smp_q;
    logic combo_deb_q;

    assign awake_pins = ~sleep_mode | cfg_q.sleep_rst_en;
    assign combo_now  = reset_term(rsel_q[1:0], pin_q[0]) & reset_term(rsel_q[3:2], pin_q[1])
                      & reset_term(rsel_q[5:4], pin_q[2]) & reset_term(rsel_q[7:6], pin_q[3]);

    always_ff @(posedge clk) begin
        if (reset) begin
            combo_smp_q <= 1'b0;
            combo_deb_q <= 1'b0;
        end else if (ck8_tick) begin
            combo_smp_q <= combo_now;
            combo_deb_q <= (combo_smp_q == combo_now) ? combo_now : combo_deb_q;
        end
    end

    // Pull enables ignore the pull-up or pull-down choice, which is fixed outside this logic.
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_input_enable        <= 4'h0;
            pin_pull_enable         <= 4'h0;
            input_reset_combination <= 1'b0;
        end else begin
            pin_input_enable        <= {4{awake_pins}};
            pin_pull_enable         <= {4{awake_pins}} & ~pin_cfg_q.no_pull;
            input_reset_combination <= sleep_mode ? (cfg_q.sleep_rst_en & combo_now) : combo_deb_q;
        end
    end

    // ************************************************************
    // Register writes and reads
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q     <= '0;
            pin_cfg_q <= '0;
            rsel_q    <= `RSEL_RESET_VALUE;
        end else if (wr_hit) begin
            case (address)
                `OFS_PRESC_CTRL: begin
                    cfg_q.pwm_en  <= writedata[`CTRL_PWM_BIT];
                    cfg_q.irq_sel <= writedata[`CTRL_IRQSEL_BIT];
                    cfg_q.deb_sel <= writedata[`CTRL_DEBOUNCE_CLOCK_SELECT_BIT];
                end
                `OFS_PIN_MASK:     pin_cfg_q.mask     <= writedata[3:0];
                `OFS_PIN_EDGE:     pin_cfg_q.edge_sel <= writedata[3:0];
                `OFS_PIN_BYPASS:   pin_cfg_q.bypass   <= writedata[3:0];
                `OFS_PIN_NOPULL:   pin_cfg_q.no_pull  <= writedata[3:0];
                `OFS_FUNC_OPTION:  cfg_q.sleep_rst_en <= writedata[`OPT_SLEEP_RST_BIT];
                `OFS_RESET_SELECT: rsel_q             <= writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_width_output_enable <= 1'b0;
        end else begin
            pulse_width_output_enable <= cfg_q.pwm_en;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if ((read | write) & ~ack_q) begin
            readdata <= 32'h0000_0000;
            if (read) begin
                case (address)
                    `OFS_PRESC_CTRL:   readdata[3:0] <= {cfg_q.pwm_en, 1'b0, cfg_q.irq_sel, cfg_q.deb_sel};
                    `OFS_PIN_LEVEL:    readdata[3:0] <= pin_q;
                    `OFS_PIN_MASK:     readdata[3:0] <= pin_cfg_q.mask;
                    `OFS_PIN_REQUEST:  readdata[3:0] <= req_q;
                    `OFS_PIN_EDGE:     readdata[3:0] <= pin_cfg_q.edge_sel;
                    `OFS_PIN_BYPASS:   readdata[3:0] <= pin_cfg_q.bypass;
                    `OFS_PIN_NOPULL:   readdata[3:0] <= pin_cfg_q.no_pull;
                    `OFS_FUNC_OPTION:  readdata[0]   <= cfg_q.sleep_rst_en;
                    `OFS_RESET_SELECT: readdata[7:0] <= rsel_q;
                    `OFS_DIVIDER:      readdata[14:0] <= tap_q;
                    default:           readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    tap_step_a: assert property (@(posedge clk) disable iff (reset)
        !$past(clear_wr) && !$past(reset) |-> tap_q == $past(tap_q) - 15'h0001)
        else $error("divider did not step by one");

    tap_clear_a: assert property (@(posedge clk) disable iff (reset)
        clear_wr |=> tap_q[14:1] == 14'h2000)
        else $error("divider clear gave wrong taps");

    ctrl_read_a: assert property (@(posedge clk) disable iff (reset)
        read && !ack_q && address == `OFS_PRESC_CTRL |=> readdata[`CTRL_CLEAR_BIT] == 1'b0)
        else $error("clear bit read back as one");

    sec_strobe_a: assert property (@(posedge clk) disable iff (reset)
        one_second_irq |-> $past(tap_q[`TAP_CK1], 1) && !$past(tap_prev_q[`TAP_CK1], 1))
        else $error("one second strobe without tap rise");

    sec_first_a: assert property (@(posedge clk) disable iff (reset)
        one_second_irq && !$past(clear_wr, 2) |-> tap_q == 15'h7FFE)
        else $error("one second strobe at wrong count");

    quiet_reset_a: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> (!one_second_irq && !blink_irq && !selectable_periodic_irq) [*2])
        else $error("strobe raised by leaving reset");

    blink_point_a: assert property (@(posedge clk) disable iff (reset)
        blink_irq |-> $past(tap_q[14:13], 1) == 2'b00 && $past(tap_prev_q[13], 1))
        else $error("blink strobe off the three quarter point");

    mask_hold_a: assert property (@(posedge clk) disable iff (reset)
        !pin_cfg_q.mask[0] && !req_q[0] |=> !req_q[0])
        else $error("masked edge was stored");

    edge_store_a: assert property (@(posedge clk) disable iff (reset)
        edge_ev[0] && pin_cfg_q.mask[0] |=> req_q[0])
        else $error("unmasked edge not stored");

    req_clear_a: assert property (@(posedge clk) disable iff (reset)
        req_clr[1] && !(edge_ev[1] && pin_cfg_q.mask[1]) |=> !req_q[1])
        else $error("write one did not clear request");

    mask_reset_a: assert property (@(posedge clk) disable iff (reset)
        $past(reset) |-> pin_cfg_q.mask == 4'h0 && req_q == 4'h0)
        else $error("mask not cleared by reset");

    sleep_off_a: assert property (@(posedge clk) disable iff (reset)
        sleep_mode && !cfg_q.sleep_rst_en |=> pin_input_enable == 4'h0 && pin_pull_enable == 4'h0)
        else $error("pins left active in sleep");

    bus_answer_a: assert property (@(posedge clk) disable iff (reset)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");

    sec_seen_c: cover property (@(posedge clk) disable iff (reset) one_second_irq);
    per_seen_c: cover property (@(posedge clk) disable iff (reset) selectable_periodic_irq && cfg_q.irq_sel);
    edge_swap_c: cover property (@(posedge clk) disable iff (reset) $changed(pin_cfg_q.edge_sel) ##1 req_q != 4'h0);
    combo_c: cover property (@(posedge clk) disable iff (reset) input_reset_combination);

endmodule // prescaler_port_irq

// [test/pin_source.sv]
// Model of the external switches that drive the four input pins.
`timescale 1ns/1ps

module pin_source (
    input  wire logic       clk,
    input  wire logic [3:0] level_req,
    output logic      [3:0] pins = 4'h0
);
    // Switches are always driven; bounce is made by the bench as short pulses, so the model
    // only moves on a clock edge and keeps every expected count exact.
    always @(posedge clk) begin
        pins <= level_req;
    end
endmodule // pin_source

// [test/prescaler_port_irq_tb.sv]
// Self-checking testbench for the prescaler and input port block.
`timescale 1ns/1ps
`include "prescaler_defines.svh"

module prescaler_port_irq_tb;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clk, reset, read, write, waitrequest, sleep_mode;
    logic        selectable_periodic_irq, one_second_irq, blink_irq;
    logic        pulse_width_output_enable, input_reset_combination;
    logic [5:0]  address;
    logic [31:0] writedata, readdata;
    logic [3:0]  pin_level, input_port_pin, pin_input_enable, pin_pull_enable;
    logic [14:0] divider_tap;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;

    prescaler_port_irq i_dut (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .input_port_pin, .sleep_mode, .divider_tap, .selectable_periodic_irq, .one_second_irq, .blink_irq,
        .pulse_width_output_enable, .pin_input_enable, .pin_pull_enable, .input_reset_combination);
    pin_source i_pins (.clk(clk), .level_req(pin_level), .pins(input_port_pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The ceiling sits above the whole run, of which the two full one-second periods are the longest part.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fails++;
            summarize();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int lo, input int hi, input string m);
        compares++;
        if (got < lo || got > hi) begin
            fails++;
            $display("MISMATCH at %0t: %s count %0d", $time, m, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        chk_word({31'h0, waitrequest}, 32'h0, "bus answer");
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_word(q, e, m);
    endtask

    task automatic drive(input logic [3:0] v);
        @(posedge clk);
        pin_level <= v;
        repeat (10) @(posedge clk);
    endtask

    task automatic wait_irq(input int sel, input int limit, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < limit) begin
            @(posedge clk);
            n++;
            hit = (sel == 0) ? one_second_irq === 1'b1 : (sel == 1) ? blink_irq === 1'b1
                : selectable_periodic_irq === 1'b1;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_second();
        int n;
        chk_word({29'h0, selectable_periodic_irq, one_second_irq, blink_irq}, 32'h0, "irq at reset");
        wait_irq(0, 40000, n);
        chk_cnt(n, 32766, 32772, "first second");
        wait_irq(1, 30000, n);
        chk_cnt(n, 24576, 24576, "blink");
        wait_irq(0, 10000, n);
        chk_cnt(n, 8192, 8192, "second period");
        $display("test second done");
    endtask

    task automatic t_defaults();
        logic [5:0] ofs [9] = '{`OFS_PRESC_CTRL, `OFS_PIN_MASK, `OFS_PIN_REQUEST, `OFS_PIN_EDGE,
            `OFS_PIN_BYPASS, `OFS_PIN_NOPULL, `OFS_FUNC_OPTION, `OFS_RESET_SELECT, 6'h3C};
        foreach (ofs[i]) rc(ofs[i], 32'h0, "reset value");
        $display("test defaults done");
    endtask

    task automatic t_clear();
        logic [14:0] t;
        t = divider_tap;
        @(posedge clk);
        chk_word({17'h0, divider_tap}, {17'h0, t - 15'h0001}, "count step");
        wr(`OFS_PRESC_CTRL, 32'h0000000C);
        @(posedge clk);
        chk_word({17'h0, divider_tap & 15'h7FFE}, 32'h00004000, "divider clear");
        rc(`OFS_PRESC_CTRL, 32'h00000008, "clear reads zero");
        chk_word({31'h0, pulse_width_output_enable}, 32'h1, "pwm enable");
        t = divider_tap;
        rc(`OFS_DIVIDER, {17'h0, t - 15'h0002}, "divider read");
        $display("test clear done");
    endtask

    task automatic t_periodic();
        int n;
        for (int s = 0; s < 2; s++) begin
            wr(`OFS_PRESC_CTRL, 32'(s << 1));
            repeat (2 + s) wait_irq(2, 5000, n);
            chk_cnt(n, s ? 1024 : 4096, s ? 1024 : 4096, "periodic interval");
        end
        $display("test periodic done");
    endtask

    task automatic t_direct();
        wr(`OFS_PIN_BYPASS, 32'h0000000F);
        wr(`OFS_PIN_MASK, 32'h00000001);
        drive(4'h3);
        rc(`OFS_PIN_REQUEST, 32'h00000001, "masked edge");
        wr(`OFS_PIN_MASK, 32'h00000003);
        rc(`OFS_PIN_REQUEST, 32'h00000001, "edge not kept");
        wr(`OFS_PIN_REQUEST, 32'h00000000);
        rc(`OFS_PIN_REQUEST, 32'h00000001, "write zero");
        wr(`OFS_PIN_REQUEST, 32'h00000001);
        rc(`OFS_PIN_REQUEST, 32'h00000000, "write one");
        wr(`OFS_PIN_EDGE, 32'h00000002);
        drive(4'h1);
        rc(`OFS_PIN_REQUEST, 32'h00000002, "falling edge");
        wr(`OFS_PIN_REQUEST, 32'h00000002);
        wr(`OFS_PIN_MASK, 32'h00000007);
        wr(`OFS_PIN_EDGE, 32'h00000006);
        rc(`OFS_PIN_REQUEST, 32'h00000004, "edge select change");
        drive(4'h9);
        rc(`OFS_PIN_LEVEL, 32'h00000009, "pin level");
        $display("test direct done");
    endtask

    task automatic t_debounce();
        int p;
        wr(`OFS_PIN_MASK, 32'h00000008);
        wr(`OFS_PIN_EDGE, 32'h00000000);
        wr(`OFS_PIN_BYPASS, 32'h00000000);
        for (int s = 0; s < 2; s++) begin
            p = s ? 32 : 256;
            wr(`OFS_PRESC_CTRL, 32'(s));
            drive(4'h0);
            repeat (3 * p) @(posedge clk);
            wr(`OFS_PIN_REQUEST, 32'h0000000F);
            drive(4'h8);
            drive(4'h0);
            repeat (3 * p) @(posedge clk);
            rc(`OFS_PIN_REQUEST, 32'h00000000, "glitch rejected");
            drive(4'h8);
            repeat (3 * p) @(posedge clk);
            rc(`OFS_PIN_REQUEST, 32'h00000008, "stable accepted");
        end
        $display("test debounce done");
    endtask

    task automatic t_sleep();
        wr(`OFS_RESET_SELECT, 32'h000000FF);
        repeat (800) @(posedge clk);
        chk_word({31'h0, input_reset_combination}, 32'h1, "combination awake");
        wr(`OFS_RESET_SELECT, 32'h00000055);
        wr(`OFS_PIN_NOPULL, 32'h00000005);
        sleep_mode <= 1'b1;
        drive(4'h0);
        chk_word({24'h0, pin_input_enable, pin_pull_enable}, 32'h00000000, "sleep off");
        wr(`OFS_FUNC_OPTION, 32'h00000001);
        repeat (10) @(posedge clk);
        chk_word({24'h0, pin_input_enable, pin_pull_enable}, 32'h000000FA, "sleep watch");
        chk_word({31'h0, input_reset_combination}, 32'h0, "combination low");
        drive(4'hF);
        chk_word({31'h0, input_reset_combination}, 32'h1, "combination at once");
        sleep_mode <= 1'b0;
        $display("test sleep done");
    endtask

    initial begin
        reset = 1'b1;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        pin_level = 4'h0;
        sleep_mode = 1'b0;
        repeat (8) @(posedge clk);
        chk_word({17'h0, divider_tap}, {17'h0, `TAP_RESET_VALUE}, "divider reset");
        reset <= 1'b0;
        t_second();
        t_defaults();
        t_clear();
        t_periodic();
        t_direct();
        t_debounce();
        t_sleep();
        summarize();
    end
endmodule // prescaler_port_irq_tb
